// ===== rtl/flash_cmd_pkg.sv
// constants for the serial flash setting-command decoder
// assumes a host that frames each command with chip select low
package flash_cmd_pkg;

  // command opcodes
  localparam logic [7:0] set_write_latch_cmd       = 8'h06;
  localparam logic [7:0] clear_write_latch_cmd     = 8'h04;
  localparam logic [7:0] status_read_cmd           = 8'h05;
  localparam logic [7:0] config_read_cmd           = 8'h15;
  localparam logic [7:0] status_config_write_cmd   = 8'h01;
  localparam logic [7:0] ext_addr_read_cmd         = 8'hC8;
  localparam logic [7:0] ext_addr_write_cmd        = 8'hC5;
  localparam logic [7:0] protect_scheme_select_cmd = 8'h68;
  localparam logic [7:0] four_line_enter_cmd       = 8'h35;
  localparam logic [7:0] four_line_exit_cmd        = 8'hF5;
  localparam logic [7:0] wide_address_enter_cmd    = 8'hB7;
  localparam logic [7:0] wide_address_exit_cmd     = 8'hE9;
  localparam logic [7:0] suspend_cmd               = 8'hB0;
  localparam logic [7:0] resume_cmd                = 8'h30;
  localparam logic [7:0] deep_sleep_cmd            = 8'hB9;
  localparam logic [7:0] burst_length_cmd          = 8'hC0;
  localparam logic [7:0] boot_reg_read_cmd         = 8'h16;
  localparam logic [7:0] boot_reg_write_cmd        = 8'h17;
  localparam logic [7:0] boot_reg_erase_cmd        = 8'h18;

  // byte positions inside a frame
  localparam logic [3:0] opcode_index      = 4'h0;
  localparam logic [3:0] first_data_index  = 4'h1;
  localparam logic [3:0] second_data_index = 4'h2;
  localparam logic [3:0] last_boot_index   = 4'h4;
  localparam logic [3:0] index_limit       = 4'hF;

  // bit counts per byte on the link (last bit index)
  localparam logic [2:0] single_last_bit = 3'h7;
  localparam logic [2:0] four_last_bit   = 3'h1;

  // output enables per mode
  localparam logic [3:0] single_oe = 4'h2;
  localparam logic [3:0] four_oe   = 4'hF;

  // apb register byte addresses
  localparam logic [7:0] ctrl_addr     = 8'h00;
  localparam logic [7:0] status_addr   = 8'h04;
  localparam logic [7:0] config_addr   = 8'h08;
  localparam logic [7:0] ext_addr_addr = 8'h0C;
  localparam logic [7:0] flags_addr    = 8'h10;
  localparam logic [7:0] burst_addr    = 8'h14;
  localparam logic [7:0] boot_addr     = 8'h18;

  // status register bit positions
  localparam int busy_bit  = 0;
  localparam int latch_bit = 1;

  // flags register bit positions
  localparam int flag_latch   = 0;
  localparam int flag_four    = 1;
  localparam int flag_wide    = 2;
  localparam int flag_suspend = 3;
  localparam int flag_sleep   = 4;
  localparam int flag_protect = 5;

  // reset values
  localparam logic [7:0]  status_reset = 8'h00;
  localparam logic [7:0]  config_reset = 8'h00;
  localparam logic [7:0]  ext_reset    = 8'h00;
  localparam logic [7:0]  burst_reset  = 8'h00;
  localparam logic [31:0] boot_reset   = 32'hFFFFFFFF;

endpackage : flash_cmd_pkg

// ===== rtl/flash_setting_command_decoder.sv
// serial flash register and setting command decoder with an apb view
// assumes the host frames commands with cs_n_in and clocks sclk_in;
// link state lives on sclk_in, software sees a snapshot on mclk_in
//
// Functional notes
// - opcode 06 sets the write latch flag, in either command mode
// - opcode 04 clears the write latch flag, in either command mode
// - opcode 05 streams the status register while the host clocks
// - opcode 15 streams the configuration register in either mode
// - opcode 01 writes status from byte one, configuration from byte two
// - opcode C8 streams the extended address register in either mode
// - opcode C5 stores exactly one byte into extended address register
// - opcode 68 selects the protect scheme, single-line mode only
// - opcode 35 enters four-line mode; F5 leaves it, each mode-gated
// - opcode B7 sets the wide address flag; E9 clears it
// - opcode B0 suspends an ongoing program or erase
// - opcode 30 resumes a suspended program or erase
// - opcode B9 enters deep sleep in either mode
// - opcode C0 updates the burst length setting
// - boot register read 16 and write 17 only in single-line mode
// - wide address mode only raises flag_wide; no command here takes address bytes
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module flash_setting_command_decoder
  import flash_cmd_pkg::*;
(
  // system
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // apb slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // serial link
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic [3:0]  dq_in,
  output logic      [3:0]  dq_out,
  output logic      [3:0]  dq_oe_out
);

  // link domain state
  typedef struct packed {
    logic        rst_meta;
    logic        rst_sync;
    logic        busy_meta;
    logic        busy_sync;
    logic [7:0]  opcode;
    logic        op_live;
    logic [7:0]  status_bits;
    logic [7:0]  config_reg;
    logic [7:0]  ext_addr;
    logic [7:0]  burst_len;
    logic [31:0] boot_reg;
    logic [23:0] boot_stage;
    logic        write_latch_flag;
    logic        four_line_command_mode;
    logic        wide_address_flag;
    logic        suspended;
    logic        deep_sleep;
    logic        protect_scheme;
    logic        snap_toggle;
  } link_state_type;

  // system clock domain state
  typedef struct packed {
    logic        tog_meta;
    logic        tog_sync;
    logic        tog_prev;
    logic        array_busy;
    logic [7:0]  status_bits;
    logic        write_latch_flag;
    logic [7:0]  config_reg;
    logic [7:0]  ext_addr;
    logic [7:0]  burst_len;
    logic [31:0] boot_reg;
    logic [5:0]  flags;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sys_state_type;

  link_state_type l;
  link_state_type next_l;
  sys_state_type  m;
  sys_state_type  next_m;

  logic       byte_done;
  logic [7:0] rx_byte;
  logic [3:0] byte_index;
  logic       load;
  logic [7:0] load_byte;

  // whether an opcode may run in the present command mode
  function automatic logic cmd_allowed(input logic [7:0] op,
                                       input logic       four);
    logic ok;
    ok = 1'b0;
    case (op)
      set_write_latch_cmd,
      clear_write_latch_cmd,
      status_read_cmd,
      config_read_cmd,
      status_config_write_cmd,
      ext_addr_read_cmd,
      ext_addr_write_cmd,
      wide_address_enter_cmd,
      wide_address_exit_cmd,
      suspend_cmd,
      resume_cmd,
      deep_sleep_cmd,
      burst_length_cmd:          ok = 1'b1;
      protect_scheme_select_cmd: ok = !four;
      four_line_enter_cmd:       ok = !four;
      four_line_exit_cmd:        ok = four;
      boot_reg_read_cmd,
      boot_reg_write_cmd,
      boot_reg_erase_cmd:        ok = !four;
      default:                   ok = 1'b0;
    endcase
    return ok;
  endfunction : cmd_allowed

  // status byte as the host sees it: busy and latch are live bits
  function automatic logic [7:0] status_value(input logic [7:0] bits,
                                              input logic       latch,
                                              input logic       busy);
    logic [7:0] v;
    v = bits;
    v[busy_bit]  = busy;
    v[latch_bit] = latch;
    return v;
  endfunction : status_value

  // one boot register byte, lowest byte first
  function automatic logic [7:0] boot_byte(input logic [31:0] word,
                                           input logic [1:0]  sel);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      2'h0: v = word[7:0];
      2'h1: v = word[15:8];
      2'h2: v = word[23:16];
      2'h3: v = word[31:24];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : boot_byte

  serial_frame_port u_port (
    .sclk_in        (sclk_in),
    .cs_n_in        (cs_n_in),
    .dq_in          (dq_in),
    .dq_out         (dq_out),
    .dq_oe_out      (dq_oe_out),
    .four_line_in   (l.four_line_command_mode),
    .load_in        (load),
    .load_byte_in   (load_byte),
    .byte_done_out  (byte_done),
    .byte_out       (rx_byte),
    .byte_index_out (byte_index)
  );

  // link side decode: acts on the edge that completes each byte, since
  // the link clock may stop right after the last bit of a frame
  always_comb begin
    logic busy_now;
    busy_now  = l.busy_sync && !l.suspended;
    next_l    = l;
    load      = 1'b0;
    load_byte = 8'h00;
    next_l.rst_meta  = rst_in;
    next_l.rst_sync  = l.rst_meta;
    next_l.busy_meta = m.array_busy;
    next_l.busy_sync = l.busy_meta;
    if (l.rst_sync) begin
      next_l.opcode                 = 8'h00;
      next_l.op_live                = 1'b0;
      next_l.status_bits            = status_reset;
      next_l.config_reg             = config_reset;
      next_l.ext_addr               = ext_reset;
      next_l.burst_len              = burst_reset;
      next_l.boot_reg               = boot_reset;
      next_l.boot_stage             = 24'h000000;
      next_l.write_latch_flag       = 1'b0;
      next_l.four_line_command_mode = 1'b0;
      next_l.wide_address_flag      = 1'b0;
      next_l.suspended              = 1'b0;
      next_l.deep_sleep             = 1'b0;
      next_l.protect_scheme         = 1'b0;
      next_l.snap_toggle            = 1'b0;
    end else if (byte_done) begin
      next_l.snap_toggle = !l.snap_toggle;
      if (byte_index == opcode_index) begin
        next_l.opcode  = rx_byte;
        next_l.op_live = !l.deep_sleep &&
                         cmd_allowed(rx_byte, l.four_line_command_mode);
        if (next_l.op_live) begin
          case (rx_byte)
            set_write_latch_cmd:   next_l.write_latch_flag = 1'b1;
            clear_write_latch_cmd: next_l.write_latch_flag = 1'b0;
            status_read_cmd: begin
              load      = 1'b1;
              load_byte = status_value(l.status_bits,
                                       l.write_latch_flag, busy_now);
            end
            config_read_cmd: begin
              load      = 1'b1;
              load_byte = l.config_reg;
            end
            ext_addr_read_cmd: begin
              load      = 1'b1;
              load_byte = l.ext_addr;
            end
            boot_reg_read_cmd: begin
              load      = 1'b1;
              load_byte = boot_byte(l.boot_reg, 2'h0);
            end
            protect_scheme_select_cmd: next_l.protect_scheme = 1'b1;
            four_line_enter_cmd: next_l.four_line_command_mode = 1'b1;
            four_line_exit_cmd:  next_l.four_line_command_mode = 1'b0;
            wide_address_enter_cmd: next_l.wide_address_flag = 1'b1;
            wide_address_exit_cmd:  next_l.wide_address_flag = 1'b0;
            suspend_cmd: begin
              // nothing to hold when no program or erase is running
              if (l.busy_sync) begin
                next_l.suspended = 1'b1;
              end
            end
            resume_cmd:         next_l.suspended  = 1'b0;
            deep_sleep_cmd:     next_l.deep_sleep = 1'b1;
            boot_reg_erase_cmd: next_l.boot_reg   = boot_reset;
            default: ;
          endcase
        end
      end else if (l.op_live) begin
        case (l.opcode)
          status_read_cmd: begin
            load      = 1'b1;
            load_byte = status_value(l.status_bits,
                                     l.write_latch_flag, busy_now);
          end
          config_read_cmd: begin
            load      = 1'b1;
            load_byte = l.config_reg;
          end
          ext_addr_read_cmd: begin
            load      = 1'b1;
            load_byte = l.ext_addr;
          end
          boot_reg_read_cmd: begin
            load      = 1'b1;
            load_byte = boot_byte(l.boot_reg, byte_index[1:0]);
          end
          status_config_write_cmd: begin
            if (byte_index == first_data_index) begin
              next_l.status_bits = rx_byte;
            end else if (byte_index == second_data_index) begin
              next_l.config_reg = rx_byte;
            end
          end
          ext_addr_write_cmd: begin
            if (byte_index == first_data_index) begin
              next_l.ext_addr = rx_byte;
            end
          end
          burst_length_cmd: begin
            if (byte_index == first_data_index) begin
              next_l.burst_len = rx_byte;
            end
          end
          boot_reg_write_cmd: begin
            // a short write leaves the old word; only four bytes commit
            if (byte_index < last_boot_index) begin
              next_l.boot_stage = {rx_byte, l.boot_stage[23:8]};
            end else if (byte_index == last_boot_index) begin
              next_l.boot_reg = {rx_byte, l.boot_stage};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // link state; rst_in reaches it only while the link clock runs
  always_ff @(posedge sclk_in) begin
    l <= next_l;
  end

  // system side: snapshot capture and apb slave
  always_comb begin
    logic        setup;
    logic        access;
    logic        mapped;
    logic [31:0] rdata;
    setup  = psel_in && !penable_in;
    access = psel_in && penable_in && m.pready;
    mapped = 1'b1;
    rdata  = 32'h00000000;
    next_m = m;
    next_m.tog_meta = l.snap_toggle;
    next_m.tog_sync = m.tog_meta;
    next_m.tog_prev = m.tog_sync;
    // the link words are steady here: they changed with the toggle and
    // cannot change again before the next completed byte
    if (m.tog_sync != m.tog_prev) begin
      next_m.status_bits      = l.status_bits;
      next_m.write_latch_flag = l.write_latch_flag;
      next_m.config_reg       = l.config_reg;
      next_m.ext_addr         = l.ext_addr;
      next_m.burst_len        = l.burst_len;
      next_m.boot_reg         = l.boot_reg;
      next_m.flags[flag_latch]   = l.write_latch_flag;
      next_m.flags[flag_four]    = l.four_line_command_mode;
      next_m.flags[flag_wide]    = l.wide_address_flag;
      next_m.flags[flag_suspend] = l.suspended;
      next_m.flags[flag_sleep]   = l.deep_sleep;
      next_m.flags[flag_protect] = l.protect_scheme;
    end
    case (paddr_in)
      ctrl_addr:     rdata = {31'h00000000, m.array_busy};
      status_addr:   rdata = {24'h000000,
                              status_value(m.status_bits,
                                           m.write_latch_flag,
                                           m.array_busy &&
                                           !m.flags[flag_suspend])};
      config_addr:   rdata = {24'h000000, m.config_reg};
      ext_addr_addr: rdata = {24'h000000, m.ext_addr};
      flags_addr:    rdata = {26'h0000000, m.flags};
      burst_addr:    rdata = {24'h000000, m.burst_len};
      boot_addr:     rdata = m.boot_reg;
      default:       mapped = 1'b0;
    endcase
    next_m.pready  = setup;
    next_m.pslverr = setup && !mapped;
    next_m.prdata  = (setup && !pwrite_in && mapped) ? rdata : 32'h00000000;
    if (access && pwrite_in && paddr_in == ctrl_addr) begin
      next_m.array_busy = pwdata_in[0];
    end
    if (rst_in) begin
      next_m.array_busy       = 1'b0;
      next_m.status_bits      = status_reset;
      next_m.write_latch_flag = 1'b0;
      next_m.config_reg       = config_reset;
      next_m.ext_addr         = ext_reset;
      next_m.burst_len        = burst_reset;
      next_m.boot_reg         = boot_reset;
      next_m.flags            = 6'h00;
      next_m.prdata           = 32'h00000000;
      next_m.pready           = 1'b0;
      next_m.pslverr          = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    m <= next_m;
  end

  assign prdata_out  = m.prdata;
  assign pready_out  = m.pready;
  assign pslverr_out = m.pslverr;

endmodule : flash_setting_command_decoder
`default_nettype wire

// ===== rtl/serial_frame_port.sv
// serial link shifter: collects command bytes and drives read data
// assumes sclk_in runs only inside frames; chip select high clears it
`timescale 1ns/100ps
`default_nettype none
module serial_frame_port
  import flash_cmd_pkg::*;
(
  // link
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] dq_in,
  output logic      [3:0] dq_out,
  output logic      [3:0] dq_oe_out,
  // decoder side
  input  wire logic       four_line_in,
  input  wire logic       load_in,
  input  wire logic [7:0] load_byte_in,
  output logic            byte_done_out,
  output logic      [7:0] byte_out,
  output logic      [3:0] byte_index_out
);

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [3:0] byte_cnt;
    logic [6:0] shift_in;
    logic [7:0] tx_shift;
    logic       tx_on;
    logic [3:0] dq;
    logic [3:0] oe;
  } port_state_type;

  port_state_type s;
  port_state_type next_s;
  logic           last;

  always_comb begin
    last = (s.bit_cnt == (four_line_in ? four_last_bit : single_last_bit));
    byte_done_out  = last;
    byte_index_out = s.byte_cnt;
    byte_out = four_line_in ? {s.shift_in[3:0], dq_in}
                            : {s.shift_in[6:0], dq_in[0]};
    next_s = s;
    next_s.bit_cnt  = last ? 3'h0 : s.bit_cnt + 3'h1;
    next_s.shift_in = four_line_in ? {s.shift_in[2:0], dq_in}
                                   : {s.shift_in[5:0], dq_in[0]};
    if (last && s.byte_cnt != index_limit) begin
      next_s.byte_cnt = s.byte_cnt + 4'h1;
    end
    if (load_in) begin
      next_s.tx_shift = load_byte_in;
      next_s.tx_on    = 1'b1;
    end else if (four_line_in) begin
      next_s.tx_shift = {s.tx_shift[3:0], 4'h0};
    end else begin
      next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
    end
    next_s.dq = four_line_in ? next_s.tx_shift[7:4]
                             : {2'b00, next_s.tx_shift[7], 1'b0};
    next_s.oe = next_s.tx_on ? (four_line_in ? four_oe : single_oe) : 4'h0;
  end

  // a frame ends on chip select alone, so no link edge is needed after it
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dq_out    = s.dq;
  assign dq_oe_out = s.oe;

endmodule : serial_frame_port
`default_nettype wire

// ===== testbench/flash_decoder_checker.sv
// checker: apb answer and link output-enable relations at the ports
// assumes an apb master that keeps the two-phase protocol
`timescale 1ns/100ps
`default_nettype none
module flash_decoder_checker
  import flash_cmd_pkg::*;
(
  // system
  input wire logic        mclk_in,
  input wire logic        rst_in,
  // apb
  input wire logic [7:0]  paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // link
  input wire logic        cs_n_in,
  input wire logic [3:0]  dq_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in && pready_out;
  endsequence
  property p_answer; s_setup |=> s_access; endproperty
  property p_one; pready_out |=> !pready_out; endproperty
  property p_idle; !psel_in |-> !pready_out; endproperty
  property p_err; pslverr_out |-> pready_out; endproperty
  property p_zero; !pready_out |-> prdata_out == 32'h0; endproperty
  property p_unmapped;
    s_setup ##0 (paddr_in > boot_addr) |=> pslverr_out;
  endproperty
  property p_mapped;
    s_setup ##0 (paddr_in <= boot_addr && paddr_in[1:0] == 2'h0)
      |=> !pslverr_out;
  endproperty
  // chip select clears the link asynchronously, so two samples suffice
  property p_oe_off;
    cs_n_in && $past(cs_n_in) |-> dq_oe_out == 4'h0;
  endproperty
  property p_oe_mode;
    dq_oe_out != 4'h0 |-> dq_oe_out == single_oe || dq_oe_out == four_oe;
  endproperty
  property p_oe_frame; $rose(dq_oe_out[1]) |-> !cs_n_in; endproperty
  a_answer: assert property (p_answer) else $error("no apb answer");
  a_one: assert property (p_one) else $error("ready held too long");
  a_idle: assert property (p_idle) else $error("ready without select");
  a_err: assert property (p_err) else $error("error without ready");
  a_zero: assert property (p_zero) else $error("read data not zero");
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  a_mapped: assert property (p_mapped) else $error("false slave error");
  a_oe_off: assert property (p_oe_off) else $error("driving idle link");
  a_oe_mode: assert property (p_oe_mode) else $error("odd enables");
  a_oe_frame: assert property (p_oe_frame) else $error("late drive");
endmodule : flash_decoder_checker
bind flash_setting_command_decoder flash_decoder_checker chk (.mclk_in,
  .rst_in, .paddr_in, .psel_in, .penable_in, .prdata_out, .pready_out,
  .pslverr_out, .cs_n_in, .dq_oe_out);
`default_nettype wire

// ===== testbench/flash_host_model.sv
// host model: frames commands on the link and samples the replies
// assumes the decoder launches replies on the rising link clock
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
  // link
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic      [3:0] dq_out,
  input  wire logic [3:0] dq_in
);
  logic four = 1'b0;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    dq_out   = 4'h5;
  end
  // one 160 ns link clock; reply sampled just before the rise
  task automatic tick(output logic [3:0] s);
    #80;
    s = dq_in;
    sclk_out = 1'b1;
    #80;
    sclk_out = 1'b0;
  endtask : tick
  task automatic idle_clocks(input int n);
    logic [3:0] s;
    repeat (n) tick(s);
  endtask : idle_clocks
  task automatic frame(input int n, input logic [39:0] tx,
                       output logic [39:0] rx);
    logic [3:0] s;
    int         b;
    rx = 40'h0;
    cs_n_out = 1'b0;
    for (b = 0; b < n * 8; b += (four ? 4 : 1)) begin
      // lines the host does not own in single mode keep toggling
      dq_out = four ? tx[39 - b -: 4] : {~dq_out[3:1], tx[39 - b]};
      tick(s);
      if (four) rx[39 - b -: 4] = s;
      else rx[39 - b] = s[1];
    end
    #40;
    cs_n_out = 1'b1;
    dq_out = ~dq_out;
    #200;
  endtask : frame
endmodule : flash_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
// top bench: apb master, scenario tasks and verdict for the decoder
// assumes the host model drives the link at its own unrelated rate
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import flash_cmd_pkg::*;
();
  logic        mclk_in    = 1'b0;
  logic        rst_in     = 1'b1;
  logic [7:0]  paddr_in   = 8'h00;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [31:0] pwdata_in  = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        sclk_in;
  logic        cs_n_in;
  logic [3:0]  dq_in;
  logic [3:0]  dq_out;
  logic [3:0]  dq_oe_out;
  logic [3:0]  line_dq;
  logic [39:0] rx;
  logic [31:0] q;
  logic        e;
  int          miscompares     = 0;
  int          samples_checked = 0;
  flash_setting_command_decoder DUT (.mclk_in, .rst_in, .paddr_in,
    .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .sclk_in, .cs_n_in, .dq_in, .dq_out,
    .dq_oe_out);
  flash_host_model host (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
    .dq_out(dq_in), .dq_in(line_dq));
  // undriven lines show a pattern that changes every cycle
  assign line_dq = (dq_out & dq_oe_out) | (~dq_oe_out & {4{mclk_in}});
  initial forever #12.5 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one idle edge first, so a release never meets the next request
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // snapshot registers trail a completed link byte by a few cycles
  task automatic send(input int n, input logic [39:0] tx);
    host.frame(n, tx, rx);
    repeat (8) @(posedge mclk_in);
  endtask : send
  task automatic t_regs;
    rd(boot_addr, boot_reset);
    apb(1'b1, status_addr, 32'hFF);
    rd(status_addr, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask : t_regs
  task automatic t_latch;
    send(1, {set_write_latch_cmd, 32'h0});
    rd(flags_addr, 32'h1);
    rd(status_addr, 32'h2);
    send(3, {status_read_cmd, 32'h0});
    chk({16'h0, rx[31:16]}, 32'h0202);
    send(1, {clear_write_latch_cmd, 32'h0});
    rd(flags_addr, 32'h0);
  endtask : t_latch
  task automatic t_regwrite;
    send(3, {status_config_write_cmd, 16'hA45C, 16'h0});
    rd(status_addr, 32'hA4);
    rd(config_addr, 32'h5C);
    send(2, {config_read_cmd, 32'h0});
    chk({24'h0, rx[31:24]}, 32'h5C);
    send(2, {ext_addr_write_cmd, 8'h3E, 24'h0});
    rd(ext_addr_addr, 32'h3E);
    send(2, {ext_addr_read_cmd, 32'h0});
    chk({24'h0, rx[31:24]}, 32'h3E);
  endtask : t_regwrite
  task automatic t_modes;
    send(1, {four_line_exit_cmd, 32'h0});
    rd(flags_addr, 32'h0);
    send(1, {protect_scheme_select_cmd, 32'h0});
    rd(flags_addr, 32'h20);
    send(1, {four_line_enter_cmd, 32'h0});
    rd(flags_addr, 32'h22);
    host.four = 1'b1;
    send(1, {set_write_latch_cmd, 32'h0});
    rd(flags_addr, 32'h23);
    send(2, {config_read_cmd, 32'h0});
    chk({24'h0, rx[31:24]}, 32'h5C);
    send(5, {boot_reg_write_cmd, 32'h12345678});
    rd(boot_addr, boot_reset);
    send(1, {four_line_exit_cmd, 32'h0});
    host.four = 1'b0;
    send(1, {clear_write_latch_cmd, 32'h0});
    rd(flags_addr, 32'h20);
  endtask : t_modes
  task automatic t_wide;
    send(1, {wide_address_enter_cmd, 32'h0});
    rd(flags_addr, 32'h24);
    send(1, {wide_address_exit_cmd, 32'h0});
    rd(flags_addr, 32'h20);
  endtask : t_wide
  task automatic t_suspend;
    apb(1'b1, ctrl_addr, 32'h1);
    rd(status_addr, 32'hA5);
    send(1, {suspend_cmd, 32'h0});
    rd(flags_addr, 32'h28);
    rd(status_addr, 32'hA4);
    send(1, {resume_cmd, 32'h0});
    rd(flags_addr, 32'h20);
    rd(status_addr, 32'hA5);
    apb(1'b1, ctrl_addr, 32'h0);
  endtask : t_suspend
  task automatic t_boot;
    send(2, {burst_length_cmd, 8'h5A, 24'h0});
    rd(burst_addr, 32'h5A);
    send(5, {boot_reg_write_cmd, 32'h11223344});
    rd(boot_addr, 32'h44332211);
    send(3, {boot_reg_read_cmd, 32'h0});
    chk({16'h0, rx[31:16]}, 32'h1122);
    send(1, {boot_reg_erase_cmd, 32'h0});
    rd(boot_addr, boot_reset);
  endtask : t_boot
  task automatic t_sleep;
    send(1, {8'hAA, 32'h0});
    rd(flags_addr, 32'h20);
    send(1, {deep_sleep_cmd, 32'h0});
    rd(flags_addr, 32'h30);
    send(1, {set_write_latch_cmd, 32'h0});
    rd(flags_addr, 32'h30);
  endtask : t_sleep
  task automatic final_report;
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    miscompares++;
    final_report;
  end
  // link reset needs running link clocks, so reset spans four link cycles
  initial begin
    host.idle_clocks(4);
    @(posedge mclk_in);
    rst_in <= 1'b0;
    host.idle_clocks(3);
    @(posedge mclk_in);
    t_regs;
    t_latch;
    t_regwrite;
    t_modes;
    t_wide;
    t_suspend;
    t_boot;
    t_sleep;
    final_report;
  end
endmodule : tb_top
`default_nettype wire
